// >>> logic/acb_dev.sv
// Summary of operation
// R1: Sixty-four eight-bit registers, host read/write
// R2: Six-bit address, bit five most significant
// R3: Host lowers enable with all inputs valid
// R4: Select high reads, low writes
// R5: Device pulls acknowledge low on completion
// R6: Read data and parity driven during acknowledge
// R7: Host holds write data until acknowledge
// R8: Host holds write parity until acknowledge
// R9: Acknowledge stays low while enable low
// R10: Odd parity over eight data bits
// R11: Bad write parity blocks update, sets flag
// R12: Interrupt low while unmasked condition pending
// R13: Host reads cause register after interrupt
// R14: Mask register gates each interrupt condition
// R15: Release acknowledge and bus between cycles
`timescale 1ns/1ns
module acb_dev
  import acb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  acb_if.dev bus,
  input wire logic [ACB_NEV-1:0] event_pulse,
  output logic [ACB_NREG*ACB_DW-1:0] reg_image
);
  // ***************************************
  // State
  // ***************************************
  typedef enum logic [2:0] {
    ACB_IDLE = 3'b001,
    ACB_ACK = 3'b010,
    ACB_DONE = 3'b100
  } acb_dst_t;

  typedef struct packed {
    logic [1:0] ce_s;
    logic [1:0] rd_s;
    logic [11:0] addr_s;
    logic [15:0] data_s;
    logic [1:0] par_s;
    acb_dst_t st;
    logic [7:0] rdata;
    logic rpar;
    logic drive;
    logic ack;
    logic [ACB_NREG*ACB_DW-1:0] regs;
  } acb_dev_state_t;

  acb_dev_state_t s;
  acb_dev_state_t next_s;
  logic [5:0] a;
  logic [7:0] wd;
  logic [7:0] cause;
  logic [7:0] mask;

  // Second synchroniser stage is the only one read by logic
  assign a = s.addr_s[11:6];
  assign wd = s.data_s[15:8];
  assign cause = s.regs[ACB_ADDR_ICR*ACB_DW +: ACB_DW];
  assign mask = s.regs[ACB_ADDR_IRQ_MASK_REG*ACB_DW +: ACB_DW];

  // ***************************************
  // Next state
  // ***************************************
  always_comb begin
    next_s = s;
    next_s.ce_s = {s.ce_s[0], bus.ce_n};
    next_s.rd_s = {s.rd_s[0], bus.rd_wr};
    next_s.addr_s = {s.addr_s[5:0], bus.reg_addr}; // R2
    next_s.data_s = {s.data_s[7:0], bus.mgmt_data};
    next_s.par_s = {s.par_s[0], bus.mgmt_data_parity};
    // Internal events set cause bits; set wins over any write in the same cycle
    unique case (s.st)
      ACB_IDLE: begin
        // Select, address and data pass the same two stages as enable, so they line up with it
        if (!s.ce_s[1]) begin // R3
          next_s.st = ACB_ACK;
          if (s.rd_s[1]) begin // R4
            next_s.rdata = s.regs[a*ACB_DW +: ACB_DW]; // R1
            next_s.rpar = ~^s.regs[a*ACB_DW +: ACB_DW]; // R10
            next_s.drive = 1'b1; // R6
          end else if ((^wd) ^ s.par_s[1]) begin // R10
            next_s.regs[a*ACB_DW +: ACB_DW] = wd; // R1
          end else begin
            next_s.regs[ACB_ADDR_ICR*ACB_DW + ACB_CPE_BIT] = 1'b1; // R11
          end
        end
      end
      ACB_ACK: begin
        next_s.ack = 1'b1; // R5
        next_s.st = ACB_DONE;
      end
      ACB_DONE: begin
        // Hold until host lifts enable, then release everything
        if (s.ce_s[1]) begin // R9
          next_s.ack = 1'b0; // R15
          next_s.drive = 1'b0; // R15
          next_s.st = ACB_IDLE;
        end
      end
    endcase
    next_s.regs[ACB_ADDR_ICR*ACB_DW+1 +: ACB_NEV] =
      next_s.regs[ACB_ADDR_ICR*ACB_DW+1 +: ACB_NEV] | event_pulse;
    if (rst) begin
      next_s = '0;
      next_s.ce_s = 2'b11;
      next_s.st = ACB_IDLE;
      next_s.regs = {ACB_NREG{ACB_REG_RST}};
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // ***************************************
  // Pins
  // ***************************************
  assign bus.ack_oe = s.ack; // R5
  assign bus.mgmt_data_oe_dev = s.drive; // R6
  assign bus.mgmt_data_o_dev = s.rdata;
  assign bus.mgmt_data_parity_o_dev = s.rpar;
  assign bus.int_oe = |(cause & ~mask); // R12 R14
  assign reg_image = s.regs;
endmodule // acb_dev

// >>> logic/acb_host.sv
`timescale 1ns/1ns
module acb_host
  import acb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  acb_if.host bus,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [5:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_parity_ok,
  output logic rsp_timeout,
  output logic irq
);
  // ***************************************
  // State
  // ***************************************
  typedef enum logic [2:0] {
    ACB_H_IDLE = 3'b001,
    ACB_H_WAIT = 3'b010,
    ACB_H_REL = 3'b100
  } acb_hst_t;

  typedef struct packed {
    logic [1:0] ack_s;
    logic [1:0] int_s;
    acb_hst_t st;
    logic ce_n;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] timer;
    logic rv;
    logic [7:0] rdata;
    logic pok;
    logic tmo;
  } acb_host_state_t;

  acb_host_state_t s;
  acb_host_state_t next_s;

  // Next state; bus data sampled when acknowledge is seen, already settled
  always_comb begin
    next_s = s;
    next_s.ack_s = {s.ack_s[0], bus.ack_n};
    next_s.int_s = {s.int_s[0], bus.int_n};
    next_s.rv = 1'b0;
    unique case (s.st)
      ACB_H_IDLE: begin
        if (req_valid) begin
          next_s.rd = req_read; // R4
          next_s.addr = req_addr; // R2
          next_s.wdata = req_wdata;
          next_s.ce_n = 1'b0; // R3
          next_s.timer = 8'h00;
          next_s.st = ACB_H_WAIT;
        end
      end
      ACB_H_WAIT: begin
        next_s.timer = s.timer + 8'h01;
        if (!s.ack_s[1] || s.timer == ACB_ACK_TIMEOUT) begin // R7 R8
          next_s.rdata = bus.mgmt_data;
          next_s.pok = (^bus.mgmt_data) ^ bus.mgmt_data_parity; // R10
          next_s.tmo = s.ack_s[1];
          next_s.rv = 1'b1;
          next_s.ce_n = 1'b1;
          next_s.st = ACB_H_REL;
        end
      end
      ACB_H_REL: begin
        // Wait for acknowledge release before a new cycle
        if (s.ack_s[1]) begin // R15
          next_s.st = ACB_H_IDLE;
        end
      end
    endcase
    if (rst) begin
      next_s = '0;
      next_s.ack_s = 2'b11;
      next_s.int_s = 2'b11;
      next_s.ce_n = 1'b1;
      next_s.st = ACB_H_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign req_ready = s.st == ACB_H_IDLE;
  assign rsp_valid = s.rv;
  assign rsp_rdata = s.rdata;
  assign rsp_parity_ok = s.pok;
  assign rsp_timeout = s.tmo;
  assign irq = ~s.int_s[1]; // R13
  assign bus.ce_n = s.ce_n;
  assign bus.rd_wr = s.rd;
  assign bus.reg_addr = s.addr;
  // Drive write data only in a write cycle while enable is low
  assign bus.mgmt_data_oe_host = ~s.rd & ~s.ce_n; // R7
  assign bus.mgmt_data_o_host = s.wdata;
  assign bus.mgmt_data_parity_o_host = ~^s.wdata; // R8 R10
endmodule // acb_host

// >>> logic/acb_if.sv
`timescale 1ns/1ns
// Control bus wires; open-drain lines resolve to low when any enable is set
interface acb_if;
  logic ce_n;
  logic rd_wr;
  logic [5:0] reg_addr;
  logic [7:0] mgmt_data_o_dev;
  logic mgmt_data_oe_dev;
  logic mgmt_data_parity_o_dev;
  logic [7:0] mgmt_data_o_host;
  logic mgmt_data_oe_host;
  logic mgmt_data_parity_o_host;
  logic ack_oe;
  logic int_oe;
  logic [7:0] mgmt_data;
  logic mgmt_data_parity;
  logic ack_n;
  logic int_n;
  modport dev (input ce_n, rd_wr, reg_addr, mgmt_data, mgmt_data_parity,
    output mgmt_data_o_dev, mgmt_data_oe_dev, mgmt_data_parity_o_dev, ack_oe, int_oe);
  modport host (input ack_n, int_n, mgmt_data, mgmt_data_parity,
    output ce_n, rd_wr, reg_addr, mgmt_data_o_host, mgmt_data_oe_host, mgmt_data_parity_o_host);
endinterface

// >>> logic/acb_pkg.sv
package acb_pkg;
  localparam int ACB_AW = 6;
  localparam int ACB_DW = 8;
  localparam int ACB_NREG = 64;
  // Register reset value
  localparam logic [7:0] ACB_REG_RST = 8'h00;
  // Interrupt cause and mask register addresses (parity flag in bit 0, internal events in bits 7..1)
  localparam logic [5:0] ACB_ADDR_ICR = 6'h02;
  localparam logic [5:0] ACB_ADDR_IRQ_MASK_REG = 6'h03;
  // Position of the write parity error flag in the cause register
  localparam int ACB_CPE_BIT = 0;
  // Internal event inputs land in cause bits 7..1
  localparam int ACB_NEV = 7;
  // Host side: cycles to wait for acknowledge before giving up
  localparam logic [7:0] ACB_ACK_TIMEOUT = 8'hff;
endpackage

// >>> verif/acb_asserts.sv
`timescale 1ns/1ns
// ****************
// Control bus checks
// ****************
module acb_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic rd_wr,
  input wire logic [7:0] mgmt_data,
  input wire logic mgmt_data_parity,
  input wire logic mgmt_data_oe_dev,
  input wire logic mgmt_data_oe_host,
  input wire logic ack_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Acknowledge only answers an enabled cycle, and promptly
  a_ack_needs_ce: assert property ($rose(ack_oe) |-> !ce_n) else $error("ack without enable");
  a_ack_comes_soon: assert property ($fell(ce_n) |-> ##[1:10] ack_oe) else $error("ack late");
  a_ack_holds_low: assert property (ack_oe && !ce_n |=> ack_oe) else $error("ack dropped early");
  // Sync delay lets ack linger a few cycles past enable
  a_ack_releases: assert property ($rose(ce_n) |-> ##[1:4] !ack_oe) else $error("ack stuck");
  a_read_drives: assert property (ack_oe && rd_wr && !ce_n |-> mgmt_data_oe_dev) else $error("read undriven");
  a_read_odd_par: assert property (ack_oe && rd_wr && !ce_n |-> ^{mgmt_data, mgmt_data_parity})
    else $error("read parity even");
  a_write_quiet: assert property (!ce_n && !rd_wr |-> !mgmt_data_oe_dev) else $error("device drives on write");
  a_one_driver: assert property (!(mgmt_data_oe_dev && mgmt_data_oe_host)) else $error("bus contention");
  a_write_stable: assert property (!ce_n && !ack_oe && !rd_wr |=>
    ce_n || $stable({mgmt_data, mgmt_data_parity})) else $error("write data moved");
  c_read: cover property (ack_oe && rd_wr);
  c_write: cover property (ack_oe && !rd_wr);
  c_start: cover property ($fell(ce_n));
endmodule // acb_asserts

// >>> verif/test_async_control_bus_port.sv
`timescale 1ns/1ns
// ****************
// Host to device bench
// ****************
module test_async_control_bus_port;
  import acb_pkg::*;
  logic clk, rst, tgl, req_valid, req_read, req_ready, rsp_valid, rsp_parity_ok, rsp_timeout, irq, m0, m1;
  logic [5:0] req_addr;
  logic [7:0] req_wdata, rsp_rdata, rd;
  logic [6:0] ev;
  logic [511:0] img, img2;
  logic [5:0] av [4] = '{6'h00, 6'h01, 6'h20, 6'h3f};
  logic [7:0] dv [4] = '{8'h00, 8'hff, 8'h01, 8'ha5};
  int n_errors, n_tests, k;
  acb_if b();
  acb_if b2();
  // Wire resolution; a released bus shows a pattern that flips every cycle
  assign b.mgmt_data = b.mgmt_data_oe_dev ? b.mgmt_data_o_dev : b.mgmt_data_oe_host ? b.mgmt_data_o_host : {8{tgl}};
  assign b.mgmt_data_parity = b.mgmt_data_oe_dev ? b.mgmt_data_parity_o_dev :
    b.mgmt_data_oe_host ? b.mgmt_data_parity_o_host : ~tgl;
  assign b.ack_n = ~b.ack_oe;
  assign b.int_n = ~b.int_oe;
  assign b2.mgmt_data = b2.mgmt_data_oe_host ? b2.mgmt_data_o_host : {8{tgl}};
  assign b2.mgmt_data_parity = b2.mgmt_data_oe_host ? b2.mgmt_data_parity_o_host : ~tgl;
  assign b2.ack_n = ~b2.ack_oe;
  assign b2.int_n = ~b2.int_oe;
  acb_host acb_host_inst (.clk(clk), .rst(rst), .bus(b.host), .req_valid(req_valid), .req_read(req_read),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_parity_ok(rsp_parity_ok), .rsp_timeout(rsp_timeout), .irq(irq));
  acb_dev acb_dev_inst (.clk(clk), .rst(rst), .bus(b.dev), .event_pulse(ev), .reg_image(img));
  // Second device faces a bench driver that breaks parity on purpose
  acb_dev acb_dev_inst_b (.clk(clk), .rst(rst), .bus(b2.dev), .event_pulse(7'h00), .reg_image(img2));
  acb_asserts acb_asserts_inst (.clk(clk), .rst(rst), .ce_n(b.ce_n), .rd_wr(b.rd_wr), .mgmt_data(b.mgmt_data),
    .mgmt_data_parity(b.mgmt_data_parity), .mgmt_data_oe_dev(b.mgmt_data_oe_dev),
    .mgmt_data_oe_host(b.mgmt_data_oe_host), .ack_oe(b.ack_oe));
  // Clock and floating-bus pattern
  initial begin
    clk = 0;
    tgl = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tgl <= ~tgl;
  task chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // One request through the host; waits are bounded
  task xfer(input logic r, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1;
    req_read = r;
    req_addr = a;
    req_wdata = d;
    k = 0;
    while (req_ready !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    rd = rsp_rdata;
    chk(rsp_parity_ok === 1'b1 && rsp_timeout === 1'b0 && k < 300, "cycle failed");
  endtask
  task close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    close_out;
  end
  initial begin
    rst = 1;
    {req_valid, req_read, req_addr, req_wdata, ev} = '0;
    {b2.rd_wr, b2.reg_addr, b2.mgmt_data_o_host, b2.mgmt_data_oe_host, b2.mgmt_data_parity_o_host} = '0;
    b2.ce_n = 1;
    repeat (3) @(negedge clk);
    rst = 0;
    foreach (av[i]) xfer(0, av[i], dv[i]);
    foreach (av[i]) begin
      xfer(1, av[i], 8'h00);
      chk(rd === dv[i], "read back");
      chk(img[av[i]*8 +: 8] === dv[i], "address order");
    end
    // Event, then cause read, then mask both ways
    @(negedge clk) ev = 7'h01;
    @(negedge clk) ev = 7'h00;
    xfer(1, ACB_ADDR_ICR, 8'h00);
    chk(rd === 8'h02, "cause bits");
    chk(rd[ACB_CPE_BIT] === 1'b0, "false parity flag");
    xfer(0, ACB_ADDR_IRQ_MASK_REG, 8'h00);
    repeat (4) @(negedge clk);
    m0 = irq;
    xfer(0, ACB_ADDR_IRQ_MASK_REG, 8'hff);
    repeat (4) @(negedge clk);
    m1 = irq;
    chk({m0, m1} === 2'b10, "mask no effect");
    // Write 0x03 with even total parity
    @(negedge clk);
    {b2.reg_addr, b2.mgmt_data_o_host, b2.mgmt_data_oe_host, b2.ce_n} = {6'h05, 8'h03, 1'b1, 1'b0};
    k = 0;
    while (b2.ack_oe !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    {b2.mgmt_data_oe_host, b2.ce_n} = 2'b01;
    repeat (6) @(negedge clk);
    chk(k < 50 && img2[47:40] === 8'h00, "bad write landed");
    chk(img2[ACB_ADDR_ICR*8+ACB_CPE_BIT] === 1'b1, "parity flag");
    close_out;
  end
endmodule // test_async_control_bus_port
